//--- dv/spi_audio_control_fields_tb_top.sv
// Purpose: register and link scenarios for spiac_core
// Assumes: 40 MHz i_clk, far device at 200 ns bit period
// Notes:   transmit shifting is not compared, only pin ownership
`timescale 1ns/100ps
`include "spiac_defines.vh"

module spi_audio_control_fields_tb_top;
    localparam [31:0] WORD_A = 32'h9ABCDEF1;
    localparam [31:0] WORD_B = 32'h13572468;
    reg          i_clk;
    reg          i_resetn;
    reg  [4:0]   i_address;
    reg          i_read;
    reg          i_write;
    reg  [31:0]  i_writedata;
    reg          i_idle;
    wire [31:0]  o_readdata;
    wire         o_waitrequest;
    wire         i_sck;
    wire         i_fsync;
    wire         i_sdi;
    wire         o_sdo;
    wire         o_sdo_oe;
    logic [31:0] rd;
    int          error_cnt;
    int          num_checks;
    int          m;
    int          dw;
    int          cw;

    spiac_core i_dut (.i_clk, .i_resetn, .i_ce(1'b1), .i_address, .i_read, .i_write,
        .i_writedata, .o_readdata, .o_waitrequest, .i_idle, .i_sck, .i_fsync, .i_sdi,
        .o_sdo, .o_sdo_oe);
    spiac_far_model i_far (.o_sck(i_sck), .o_fsync(i_fsync), .o_sdi(i_sdi));

    // bus clock
    always #12.5 i_clk = ~i_clk;

    task finish_test;
        if (error_cnt == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one access held until waitrequest is seen low; a spare edge keeps strobes apart
    task bus(input bit wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        i_address <= a;
        i_read <= !wr;
        i_write <= wr;
        i_writedata <= d;
        @(posedge i_clk);
        while (o_waitrequest !== 1'b0 && n < 50) begin
            @(posedge i_clk);
            n++;
        end
        rd = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
        if (n == 50) error_cnt++;
        @(posedge i_clk);
    endtask

    // disable first so every scenario starts from an idle engine
    task cfg(input logic [31:0] c, input bit pol);
        bus(1, `SPIAC_OFS_CTRL, 32'h0);
        i_far.park(pol);
        repeat (8) @(posedge i_clk);
        bus(1, `SPIAC_OFS_CTRL, c);
    endtask

    // main sequence
    initial begin
        i_clk = 1'b0;
        i_resetn = 1'b0;
        i_address = 5'h00;
        i_read = 1'b0;
        i_write = 1'b0;
        i_writedata = 32'h0;
        i_idle = 1'b0;
        error_cnt = 0;
        num_checks = 0;
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        bus(0, `SPIAC_OFS_CTRL, 0);
        chk(rd, `SPIAC_CTL_RESET);
        bus(1, 5'h10, 32'hFFFFFFFF);
        bus(0, 5'h10, 0);
        chk(rd, 32'h0);
        bus(1, `SPIAC_OFS_CTRL, 32'hFFFFFFFF);
        bus(0, `SPIAC_OFS_CTRL, 0);
        chk(rd, `SPIAC_CTL_WMASK);
        // plain 8-bit words in both polarities; idle without halt keeps running
        i_idle <= 1'b1;
        for (m = 0; m < 2; m++) begin
            cfg(32'h00008000 | (m << 6), m[0]);
            i_far.frame(m[0], 0, 0, 8, 8, 1, 32'hA5 ^ m, 0);
            repeat (16) @(posedge i_clk);
            bus(0, `SPIAC_OFS_RXDATA, 0);
            chk(rd, 32'hA5 ^ m);
            bus(0, `SPIAC_OFS_STAT, 0);
            chk(rd[3], m[0]);
        end
        // halted in idle: a whole frame must leave nothing behind
        cfg(32'h0000A000, 0);
        i_far.frame(0, 0, 0, 8, 8, 1, 32'h5A, 0);
        repeat (16) @(posedge i_clk);
        bus(0, `SPIAC_OFS_STAT, 0);
        chk(rd[0], 0);
        i_idle <= 1'b0;
        // audio widths with polarity written zero, sync placement alternating
        for (m = 0; m < 4; m++) begin
            dw = (m == 2) ? 32 : (m == 3) ? 24 : 16;
            cw = (m == 0) ? 16 : 32;
            cfg(32'h00818000 | (m << 10) | ((m % 2) << 17), 1);
            i_far.frame(1, m[0], 1, dw, cw, 2, WORD_A, WORD_B);
            repeat (16) @(posedge i_clk);
            bus(0, `SPIAC_OFS_RXDATA, 0);
            chk(rd, WORD_A & (32'hFFFFFFFF >> (32 - dw)));
            bus(0, `SPIAC_OFS_RXDATA, 0);
            chk(rd, WORD_B & (32'hFFFFFFFF >> (32 - dw)));
            bus(0, `SPIAC_OFS_STAT, 0);
            chk(rd[3], 1);
        end
        // shallow buffer: the second word of a frame is lost and flagged
        cfg(32'h00808000, 1);
        i_far.frame(1, 0, 1, 16, 16, 2, WORD_A, WORD_B);
        repeat (16) @(posedge i_clk);
        bus(0, `SPIAC_OFS_STAT, 0);
        chk(rd[2:0], 3'b101);
        bus(0, `SPIAC_OFS_RXDATA, 0);
        chk(rd, WORD_A & 32'h0000FFFF);
        bus(1, `SPIAC_OFS_STAT, 32'h00000004);
        bus(0, `SPIAC_OFS_STAT, 0);
        chk(rd[2:0], 3'b000);
        // pin ownership
        cfg(32'h00009000, 0);
        repeat (4) @(posedge i_clk);
        chk(o_sdo_oe, 0);
        bus(1, `SPIAC_OFS_CTRL, 32'h00008000);
        repeat (4) @(posedge i_clk);
        chk(o_sdo_oe, 1);
        finish_test;
    end

    // watchdog, well beyond the expected run of about 2600 cycles
    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        finish_test;
    end
endmodule // spi_audio_control_fields_tb_top

bind spiac_core spiac_core_properties i_props (.i_clk, .i_resetn, .i_ce, .i_address,
    .i_read, .i_write, .i_writedata, .o_readdata, .o_waitrequest, .i_idle, .i_sck,
    .i_fsync, .i_sdi, .o_sdo, .o_sdo_oe);

//--- dv/spiac_core_properties.sv
// Purpose: concurrent checks on the ports of spiac_core
// Assumes: ctrl shadow follows every completed write to offset 0x00
// Notes:   the shadow lets field checks run without internal probes
`timescale 1ns/100ps
`include "spiac_defines.vh"

module spiac_core_properties (
    input wire        i_clk,
    input wire        i_resetn,
    input wire        i_ce,
    input wire [4:0]  i_address,
    input wire        i_read,
    input wire        i_write,
    input wire [31:0] i_writedata,
    input wire [31:0] o_readdata,
    input wire        o_waitrequest,
    input wire        i_idle,
    input wire        i_sck,
    input wire        i_fsync,
    input wire        i_sdi,
    input wire        o_sdo,
    input wire        o_sdo_oe
);
    reg  [31:0] ctl_q;
    wire        rd_done = i_read && !o_waitrequest;

    // shadow of ctrl, taken on the edge where the write completes
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            ctl_q <= 32'h00000000;
        end else if (i_write && !o_waitrequest && i_address == `SPIAC_OFS_CTRL) begin
            ctl_q <= i_writedata & `SPIAC_CTL_WMASK;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // tx writes may stall on a full holding word, so they are left out
    sequence s_req;
        (i_read || i_write) && o_waitrequest && !(i_write && i_address == 5'h0C);
    endsequence
    sequence s_ans;
        !o_waitrequest ##1 o_waitrequest;
    endsequence
    property p_answer;
        s_req |=> s_ans;
    endproperty
    property p_ctl_read;
        rd_done && i_address == 5'h00 |-> o_readdata == ctl_q;
    endproperty
    property p_unmapped;
        rd_done && (i_address[1:0] != 2'b00 || i_address[4]) |-> o_readdata == 32'h0;
    endproperty
    property p_pol;
        rd_done && i_address == 5'h04 |-> o_readdata[3] == (ctl_q[23] | ctl_q[6]);
    endproperty
    property p_off;
        (!ctl_q[15]) [*3] |-> !o_sdo_oe && !o_sdo;
    endproperty
    property p_rel;
        (ctl_q[15] && ctl_q[12]) [*3] |-> !o_sdo_oe;
    endproperty
    property p_drive;
        (ctl_q[15] && !ctl_q[12]) [*3] |-> o_sdo_oe;
    endproperty
    // three cycles of margin: the freeze may land one edge late
    property p_halt;
        (ctl_q[15] && ctl_q[13] && i_idle) [*3] |-> $stable(o_sdo);
    endproperty

    a_answer: assert property (p_answer) else $error("bus answer not one cycle");
    a_ctl_read: assert property (p_ctl_read) else $error("ctrl readback differs");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_pol: assert property (p_pol) else $error("effective polarity wrong");
    a_off: assert property (p_off) else $error("pin active while disabled");
    a_rel: assert property (p_rel) else $error("released pin still driven");
    a_drive: assert property (p_drive) else $error("pin not driven");
    a_halt: assert property (p_halt) else $error("output moved while halted");
endmodule // spiac_core_properties

//--- dv/spiac_far_model.sv
// Purpose: far serial device that clocks frames into the unit
// Assumes: half period of 100 ns, phase unrelated to i_clk
// Notes:   clock stands at idle between frames; no pull on the data line
`timescale 1ns/100ps

module spiac_far_model (
    output reg o_sck,
    output reg o_fsync,
    output reg o_sdi
);
    initial begin
        o_sck = 1'b0;
        o_fsync = 1'b0;
        o_sdi = 1'b0;
    end

    // idle level set before the unit is enabled
    task park(input bit pol);
        o_sck = pol;
    endtask

    // data and sync settle half a period before the lead edge
    task bit_clk(input bit pol, input bit d, input bit fs);
        o_sdi = d;
        o_fsync = fs;
        #100 o_sck = ~pol;
        #100 o_sck = pol;
    endtask

    // msb first, channel padding driven high so an ignored bit shows up
    task frame(input bit pol, input bit early, input bit fs, input int dw, input int cw,
               input int nch, input logic [31:0] w0, input logic [31:0] w1);
        int ch;
        int b;
        #7;
        if (early) bit_clk(pol, ~o_sdi, fs);
        for (ch = 0; ch < nch; ch++) begin
            for (b = 0; b < cw; b++) begin
                bit_clk(pol, (b < dw) ? (ch ? w1[dw-1-b] : w0[dw-1-b]) : 1'b1,
                        fs && ch == 0);
            end
        end
        o_fsync = 1'b0;
        o_sdi = ~o_sdi; // released line must not keep its last value
    endtask
endmodule // spiac_far_model

//--- logic/spiac_core.v
// Purpose: control fields and serial engine of the spi unit with audio mode
// Assumes: serial clock and frame sync come from the far device; 40 MHz i_clk
// Notes:   avalon-mm slave, waitrequest driven from a flop
// Operation
// [RULE1] audio mode forces the clock polarity to one whatever software wrote.
// [RULE2] in framed mode bit 17 picks frame sync on the first bit clock or one before.
// [RULE3] bit 16 turns the deeper two-entry receive buffering on or off.
// [RULE4] bit 15 enables the whole serial unit.
// [RULE5] bit 13 halts the unit while the device is idle, or keeps it running.
// [RULE6] bit 12 releases the serial output pin to the port, else the unit drives it.
// [RULE7] audio with width 0 1 uses 16-bit data, 16-bit fifo, 32-bit channel, 64-bit frame.
// [RULE8] audio with width 0 0 uses 16-bit data, 16-bit fifo, 16-bit channel, 32-bit frame.
// [RULE9] audio with wide bit set uses 32-bit fifo and channel, 24 or 32-bit data.
// [RULE10] polarity sets idle and active serial clock levels, one meaning idle high.
// [RULE11] software keeps unused control bits at zero in framed mode.
// [RULE12] with the unit disabled the shift and framing logic sit idle, pins undriven.
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/100ps
`include "spiac_defines.vh"

module spiac_core (
    input  wire        i_clk,
    input  wire        i_resetn,
    input  wire        i_ce,
    input  wire [4:0]  i_address,
    input  wire        i_read,
    input  wire        i_write,
    input  wire [31:0] i_writedata,
    output reg  [31:0] o_readdata,
    output reg         o_waitrequest,
    input  wire        i_idle,
    input  wire        i_sck,
    input  wire        i_fsync,
    input  wire        i_sdi,
    output reg         o_sdo,
    output reg         o_sdo_oe
);

    // width of one data word, then of one channel
    function [5:0] spiac_dw;
        input aud;
        input wide;
        input mid;
        begin
            if (wide)
                spiac_dw = (aud & mid) ? 6'h18 : 6'h20; // RULE9
            else if (mid | aud)
                spiac_dw = 6'h10; // RULE7 RULE8
            else
                spiac_dw = 6'h08;
        end
    endfunction

    function [5:0] spiac_cw;
        input aud;
        input wide;
        input mid;
        begin
            if (aud)
                spiac_cw = (wide | mid) ? 6'h20 : 6'h10; // RULE7 RULE8 RULE9
            else
                spiac_cw = spiac_dw(aud, wide, mid);
        end
    endfunction

    // left-justify a word of width dw into the 32-bit shifter
    function [31:0] spiac_align;
        input [31:0] w;
        input [5:0]  dw;
        begin
            case (dw)
                6'h08:   spiac_align = {w[7:0], 24'h000000};
                6'h10:   spiac_align = {w[15:0], 16'h0000};
                6'h18:   spiac_align = {w[23:0], 8'h00};
                default: spiac_align = w;
            endcase
        end
    endfunction

    reg  [31:0] ctrl_q;
    reg         ovf_q;
    reg  [31:0] hold_q;
    reg         hold_full_q;
    reg  [31:0] tx_sh_q;
    reg  [31:0] rx_sh_q;
    reg  [4:0]  cpos_q;
    reg         load_q;
    reg         sck_last_q;
    reg         fs_last_q;
    reg         fs_pend_q;
    wire [2:0]  pins;
    wire        sck_s;
    wire        fs_s;
    wire        sdi_s;

    // control field views
    wire        f_on    = ctrl_q[`SPIAC_CTL_ON];
    wire        f_aud   = ctrl_q[`SPIAC_CTL_AUD];
    wire        f_frm   = ctrl_q[`SPIAC_CTL_FRM];
    wire        f_fedge = ctrl_q[`SPIAC_CTL_FEDGE];
    wire        f_dbuf  = ctrl_q[`SPIAC_CTL_DBUF];
    wire        f_halt  = ctrl_q[`SPIAC_CTL_HALT];
    wire        f_rel   = ctrl_q[`SPIAC_CTL_SDOREL];
    wire        f_wide  = ctrl_q[`SPIAC_CTL_WIDE];
    wire        f_mid   = ctrl_q[`SPIAC_CTL_MID];
    wire        eff_pol = f_aud | ctrl_q[`SPIAC_CTL_CKP]; // RULE1

    wire [5:0]  dw      = spiac_dw(f_aud, f_wide, f_mid);
    wire [5:0]  cw      = spiac_cw(f_aud, f_wide, f_mid);
    wire [5:0]  dw_m1   = dw - 6'h01;
    wire [5:0]  cw_m1   = cw - 6'h01;

    // halt only while the device sits idle and software asked for it
    wire        run     = f_on & ~(f_halt & i_idle); // RULE4 RULE5

    // pin inputs through the filtered synchroniser
    spiac_sync #(
        .W(3)
    ) u_sync (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_ce     (i_ce),
        .i_async  ({i_sdi, i_fsync, i_sck}),
        .o_level  (pins)
    );

    assign sck_s = pins[0];
    assign fs_s  = pins[1];
    assign sdi_s = pins[2];

    // idle level equals the polarity; lead edge leaves idle, trail edge returns
    wire        lead    = (sck_last_q == eff_pol) & (sck_s != eff_pol); // RULE10
    wire        trail   = (sck_last_q != eff_pol) & (sck_s == eff_pol); // RULE10

    // frame start on the sampled frame-sync rise
    wire        sync_md = f_frm | f_aud;
    wire        fs_rise = fs_s & ~fs_last_q;
    wire        start   = sync_md & (f_fedge ? fs_pend_q : fs_rise); // RULE2
    wire [5:0]  idx     = start ? 6'h00 : {1'b0, cpos_q};
    wire        in_data = (idx <= dw_m1);
    wire        rx_last = (idx == dw_m1);
    wire        ch_last = (idx == cw_m1);
    // a frame start drops bits left behind by a sync lead-in clock
    wire [31:0] rx_word = start ? {31'h00000000, sdi_s} : {rx_sh_q[30:0], sdi_s};

    // receive buffer between the shifter and software
    wire        rx_push = run & lead & rx_last;
    wire        rx_rdy;
    wire        rx_val;
    wire [31:0] rx_out;
    wire        rx_pop;

    spiac_fifo #(
        .W(32),
        .D(2)
    ) u_rxbuf (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_ce        (i_ce),
        .i_limit_one (~f_dbuf), // RULE3
        .i_valid     (rx_push),
        .o_ready     (rx_rdy),
        .i_data      (rx_word),
        .o_valid     (rx_val),
        .i_ready     (rx_pop),
        .o_data      (rx_out)
    );

    // bus decode; a request completes when waitrequest is seen low
    wire        sel_ctl = (i_address == `SPIAC_OFS_CTRL);
    wire        sel_st  = (i_address == `SPIAC_OFS_STAT);
    wire        sel_rx  = (i_address == `SPIAC_OFS_RXDATA);
    wire        sel_tx  = (i_address == `SPIAC_OFS_TXDATA);
    wire        req     = i_read | i_write;
    wire        done    = req & ~o_waitrequest;
    wire        wr_done = done & i_write;
    wire        tx_wr   = wr_done & sel_tx;
    // a full holding register stalls the master instead of losing the word
    wire        stall   = i_write & sel_tx & hold_full_q;
    wire        tx_take = run & trail & load_q & hold_full_q;
    wire        ovf_set = rx_push & ~rx_rdy;
    wire        ovf_clr = wr_done & sel_st & i_writedata[`SPIAC_ST_OVF];

    assign rx_pop = done & i_read & sel_rx;

    reg  [31:0] rdata_d;
    reg         ovf_d;

    // read mux; unmapped offsets read as zero
    always @* begin
        rdata_d = 32'h00000000;
        if (sel_ctl)
            rdata_d = ctrl_q;
        else if (sel_st) begin
            rdata_d[`SPIAC_ST_RXAV]   = rx_val;
            rdata_d[`SPIAC_ST_TXFULL] = hold_full_q;
            rdata_d[`SPIAC_ST_OVF]    = ovf_q;
            rdata_d[`SPIAC_ST_POL]    = eff_pol;
            rdata_d[`SPIAC_ST_RUN]    = run;
        end else if (sel_rx & rx_val)
            rdata_d = rx_out;
    end

    // a late overflow wins over a clear in the same cycle
    always @* begin
        ovf_d = ovf_q;
        if (ovf_clr)
            ovf_d = 1'b0;
        if (ovf_set)
            ovf_d = 1'b1;
    end

    // bus handshake: one wait cycle, then completion
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_waitrequest <= 1'b1;
            o_readdata    <= 32'h00000000;
        end else if (i_ce) begin
            if (req & o_waitrequest & ~stall) begin
                o_waitrequest <= 1'b0;
                o_readdata    <= rdata_d;
            end else
                o_waitrequest <= 1'b1;
        end
    end

    // control register and overflow flag
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            ctrl_q <= `SPIAC_CTL_RESET;
            ovf_q  <= 1'b0;
        end else if (i_ce) begin
            if (wr_done & sel_ctl)
                ctrl_q <= i_writedata & `SPIAC_CTL_WMASK;
            ovf_q <= ovf_d;
        end
    end

    // transmit holding register; a bus write never meets a take
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            hold_q      <= 32'h00000000;
            hold_full_q <= 1'b0;
        end else if (i_ce) begin
            if (tx_wr) begin
                hold_q      <= i_writedata;
                hold_full_q <= 1'b1;
            end else if (tx_take)
                hold_full_q <= 1'b0;
        end
    end

    // edge history follows the pins even when halted, so no false edge on resume
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            sck_last_q <= 1'b0;
            fs_last_q  <= 1'b0;
            fs_pend_q  <= 1'b0;
        end else if (i_ce) begin
            sck_last_q <= sck_s;
            if (lead) begin
                fs_last_q <= fs_s;
                fs_pend_q <= fs_rise & f_fedge;
            end
        end
    end

    // shift engine: sample on lead, shift or load on trail
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            tx_sh_q <= 32'h00000000;
            rx_sh_q <= 32'h00000000;
            cpos_q  <= 5'h00;
            load_q  <= 1'b1;
        end else if (i_ce) begin
            if (!f_on) begin
                tx_sh_q <= 32'h00000000; // RULE12
                rx_sh_q <= 32'h00000000; // RULE12
                cpos_q  <= 5'h00; // RULE12
                load_q  <= 1'b1; // RULE12
            end else if (run) begin
                if (lead) begin
                    if (rx_last)
                        rx_sh_q <= 32'h00000000;
                    else if (in_data)
                        rx_sh_q <= rx_word;
                    cpos_q <= ch_last ? 5'h00 : idx[4:0] + 5'h01;
                    load_q <= ch_last;
                end else if (trail) begin
                    if (load_q) begin
                        // underrun sends zeros rather than stale data
                        tx_sh_q <= hold_full_q ? spiac_align(hold_q, dw) : 32'h00000000;
                        load_q  <= 1'b0;
                    end else
                        tx_sh_q <= {tx_sh_q[30:0], 1'b0};
                end
            end
        end
    end

    // pin drivers; released or disabled leaves the pin to the port
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_sdo    <= 1'b0;
            o_sdo_oe <= 1'b0;
        end else if (i_ce) begin
            o_sdo    <= f_on & tx_sh_q[31]; // RULE12
            o_sdo_oe <= f_on & ~f_rel; // RULE6 RULE12
        end
    end

endmodule // spiac_core

//--- logic/spiac_defines.vh
// Purpose: shared offsets, fields and reset values of the spi audio control block
// Assumes: byte addresses on a 32-bit avalon-mm slave
// Notes:   definitions only
`ifndef SPIAC_DEFINES_VH
`define SPIAC_DEFINES_VH

// register byte offsets
`define SPIAC_OFS_CTRL    5'h00
`define SPIAC_OFS_STAT    5'h04
`define SPIAC_OFS_RXDATA  5'h08
`define SPIAC_OFS_TXDATA  5'h0C

// spi_control fields
`define SPIAC_CTL_FRM     31
`define SPIAC_CTL_AUD     23
`define SPIAC_CTL_FEDGE   17
`define SPIAC_CTL_DBUF    16
`define SPIAC_CTL_ON      15
`define SPIAC_CTL_HALT    13
`define SPIAC_CTL_SDOREL  12
`define SPIAC_CTL_WIDE    11
`define SPIAC_CTL_MID     10
`define SPIAC_CTL_CKP     6
`define SPIAC_CTL_WMASK   32'h8083BC40
`define SPIAC_CTL_RESET   32'h00000000

// status fields
`define SPIAC_ST_RXAV     0
`define SPIAC_ST_TXFULL   1
`define SPIAC_ST_OVF      2
`define SPIAC_ST_POL      3
`define SPIAC_ST_RUN      4

`endif

//--- logic/spiac_fifo.v
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes:   i_limit_one caps occupancy at one entry
`timescale 1ns/100ps

module spiac_fifo #(
    parameter W = 32,
    parameter D = 2
) (
    input  wire         i_clk,
    input  wire         i_resetn,
    input  wire         i_ce,
    input  wire         i_limit_one,
    input  wire         i_valid,
    output wire         o_ready,
    input  wire [W-1:0] i_data,
    output wire         o_valid,
    input  wire         i_ready,
    output wire [W-1:0] o_data
);

    reg [W-1:0] mem_q [0:D-1];
    reg [1:0]   wr_q;
    reg [1:0]   rd_q;
    reg [2:0]   cnt_q;
    wire        push;
    wire        pop;
    wire [2:0]  cap;

    // shallow mode behaves as a single holding register
    assign cap     = i_limit_one ? 3'h1 : D[2:0];
    assign o_ready = (cnt_q < cap);
    assign o_valid = (cnt_q != 3'h0);
    assign o_data  = mem_q[rd_q[0]];
    assign push    = i_valid & o_ready;
    assign pop     = o_valid & i_ready;

    // pointers wrap over the two slots
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            wr_q  <= 2'h0;
            rd_q  <= 2'h0;
            cnt_q <= 3'h0;
        end else if (i_ce) begin
            if (push) begin
                mem_q[wr_q[0]] <= i_data;
                wr_q           <= {1'b0, ~wr_q[0]};
            end
            if (pop)
                rd_q <= {1'b0, ~rd_q[0]};
            if (push & ~pop)
                cnt_q <= cnt_q + 3'h1;
            else if (pop & ~push)
                cnt_q <= cnt_q - 3'h1;
        end
    end

endmodule // spiac_fifo

//--- logic/spiac_sync.v
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous to i_clk
// Notes:   output changes only when stages two and three agree
`timescale 1ns/100ps

module spiac_sync #(
    parameter W = 3
) (
    input  wire         i_clk,
    input  wire         i_resetn,
    input  wire         i_ce,
    input  wire [W-1:0] i_async,
    output reg  [W-1:0] o_level
);

    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    wire [W-1:0] agree;

    // stage one feeds only stage two
    assign agree = ~(s2_q ^ s3_q);

    // filter rejects a single-cycle disagreement
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            s1_q    <= {W{1'b0}};
            s2_q    <= {W{1'b0}};
            s3_q    <= {W{1'b0}};
            o_level <= {W{1'b0}};
        end else if (i_ce) begin
            s1_q    <= i_async;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            o_level <= (agree & s2_q) | (~agree & o_level);
        end
    end

endmodule // spiac_sync
